// ### hdl/sbc_pkg.sv
package sbc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int         CLK_PERIOD_NS = 50;
  localparam int         BIT_TIME_NS   = 1000;
  localparam int         BIT_CYC       = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] BIT_LAST      = 5'(BIT_CYC - 1);
  localparam logic [4:0] BIT_HALF      = 5'(BIT_CYC / 2);
  localparam logic [4:0] BIT_3Q        = 5'((BIT_CYC * 3) / 4);

  // ==========================================================================
  // Buffer and table geometry
  // ==========================================================================
  localparam int               BUF_BYTES = 4352;
  localparam int               BUF_AW    = 13;
  localparam int               PTR_W     = 14;
  localparam logic [PTR_W-1:0] BUF_LIMIT = 14'(BUF_BYTES);
  localparam int               NUM_TXN   = 64;
  localparam int               TXN_W     = 6;
  localparam logic [7:0]       TXN_MAX   = 8'h40;
  localparam logic [3:0]       SLOT_LAST = 4'h8;

  // ==========================================================================
  // Register indices (word addresses on the bus)
  // ==========================================================================
  localparam logic [7:0] IDX_COUNT    = 8'hE4;
  localparam logic [7:0] IDX_DATA     = 8'hE5;
  localparam logic [7:0] IDX_TSEL     = 8'hE6;
  localparam logic [7:0] IDX_OFS      = 8'hE7;
  localparam logic [7:0] IDX_TALLY    = 8'hE8;
  localparam logic [7:0] IDX_REPEAT   = 8'hE9;
  localparam logic [7:0] IDX_LEN_SEL  = 8'hF0;
  localparam logic [7:0] IDX_LEN_DATA = 8'hF1;
  localparam logic [7:0] IDX_CTRL     = 8'hF2;
  localparam logic [7:0] IDX_STATUS   = 8'hF3;

  // ==========================================================================
  // Field positions and values
  // ==========================================================================
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_REWIND = 1;
  localparam int         STAT_BERR   = 0;
  localparam int         STAT_BUSY   = 1;
  localparam logic [7:0] PTR_RST     = 8'h00;
  localparam logic [7:0] REPEAT_RST  = 8'h01;
  localparam logic [7:0] TALLY_MAX   = 8'hFF;
  localparam logic [7:0] BAD_READ    = 8'h00;
  localparam logic       WR_DIR      = 1'b0;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_BYTE, SEQ_STOP} sbc_seq_state_type;

endpackage

// ### hdl/sbc_buf_mem.sv
`timescale 1ns/1ns
`default_nettype none

module sbc_buf_mem
  import sbc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              wr_en,
  input  wire logic [BUF_AW-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic [BUF_AW-1:0] rd_addr_a,
  output logic      [7:0]        rd_data_a,
  input  wire logic [BUF_AW-1:0] rd_addr_b,
  output logic      [7:0]        rd_data_b
);

  typedef struct packed {
    logic [BUF_BYTES-1:0][7:0] mem;
  } sbc_mem_state_type;

  sbc_mem_state_type s_r;
  sbc_mem_state_type s_nxt;

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    if (wr_en && (int'(wr_addr) < BUF_BYTES)) begin
      s_nxt.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  assign rd_data_a = (int'(rd_addr_a) < BUF_BYTES) ? s_r.mem[rd_addr_a] : BAD_READ;
  assign rd_data_b = (int'(rd_addr_b) < BUF_BYTES) ? s_r.mem[rd_addr_b] : BAD_READ;

endmodule

`default_nettype wire

// ### hdl/sbc_tx_seq.sv
`timescale 1ns/1ns
`default_nettype none

module sbc_tx_seq
  import sbc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              start,
  input  wire logic              go_level,
  input  wire logic [7:0]        txn_count,
  input  wire logic [7:0]        repeat_count,
  input  wire logic [7:0]        cur_len,
  input  wire logic [7:0]        target_addr,
  input  wire logic [7:0]        buf_data,
  input  wire logic              ack_in,
  output logic      [TXN_W-1:0]  txn_idx,
  output logic      [BUF_AW-1:0] buf_addr,
  output logic                   busy,
  output logic                   seq_start,
  output logic                   ack_byte,
  output logic                   done,
  output logic                   scl_out,
  output logic                   sda_out
);

  typedef struct packed {
    sbc_seq_state_type state;
    logic [4:0]        cnt;
    logic [8:0]        shift;
    logic [3:0]        bitn;
    logic              is_addr;
    logic              acked;
    logic [7:0]        remaining;
    logic [TXN_W-1:0]  tidx;
    logic [BUF_AW-1:0] addr;
    logic [7:0]        frames;
    logic              seq_start;
    logic              ack_byte;
    logic              done;
    logic              scl;
    logic              sda;
    logic              ack_meta;
    logic              ack_sync;
  } sbc_seq_reg_type;

  sbc_seq_reg_type s_r;
  sbc_seq_reg_type s_nxt;

  // ==========================================================================
  // Serial sequencer
  // ==========================================================================
  always_comb begin
    s_nxt           = s_r;
    s_nxt.seq_start = 1'b0;
    s_nxt.ack_byte  = 1'b0;
    s_nxt.done      = 1'b0;
    s_nxt.ack_meta  = ack_in;
    s_nxt.ack_sync  = s_r.ack_meta;
    s_nxt.cnt       = (s_r.cnt == BIT_LAST) ? 5'h00 : 5'(s_r.cnt + 5'h01);
    case (s_r.state)
      SEQ_IDLE: begin
        s_nxt.cnt = 5'h00;
        s_nxt.scl = 1'b1;
        s_nxt.sda = 1'b1;
        if (start) begin
          if (txn_count == 8'h00) begin
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.state     = SEQ_START;
            s_nxt.frames    = 8'h00;
            s_nxt.tidx      = '0;
            s_nxt.addr      = '0;
            s_nxt.seq_start = 1'b1;
          end
        end
      end
      SEQ_START: begin
        s_nxt.scl = 1'b1;
        s_nxt.sda = (s_r.cnt < BIT_HALF);
        if (s_r.cnt == BIT_LAST) begin
          s_nxt.state     = SEQ_BYTE;
          s_nxt.shift     = {target_addr[7:1], WR_DIR, 1'b1};
          s_nxt.bitn      = 4'h0;
          s_nxt.is_addr   = 1'b1;
          s_nxt.remaining = cur_len;
        end
      end
      SEQ_BYTE: begin
        s_nxt.scl = (s_r.cnt >= BIT_HALF);
        s_nxt.sda = s_r.shift[8];
        if ((s_r.bitn == SLOT_LAST) && (s_r.cnt == BIT_HALF)) begin
          s_nxt.acked = ~s_r.ack_sync;
        end
        if (s_r.cnt == BIT_LAST) begin
          if (s_r.bitn != SLOT_LAST) begin
            s_nxt.shift = {s_r.shift[7:0], 1'b1};
            s_nxt.bitn  = 4'(s_r.bitn + 4'h1);
          end else begin
            s_nxt.ack_byte = ~s_r.is_addr & s_r.acked;
            if (s_r.remaining != 8'h00) begin
              s_nxt.shift     = {buf_data, 1'b1};
              s_nxt.bitn      = 4'h0;
              s_nxt.is_addr   = 1'b0;
              s_nxt.remaining = 8'(s_r.remaining - 8'h01);
              s_nxt.addr      = BUF_AW'(s_r.addr + 1'b1);
            end else if (8'(s_r.tidx + 1'b1) >= txn_count) begin
              s_nxt.state = SEQ_STOP;
            end else begin
              s_nxt.tidx  = TXN_W'(s_r.tidx + 1'b1);
              s_nxt.state = SEQ_START;
            end
          end
        end
      end
      SEQ_STOP: begin
        s_nxt.scl = (s_r.cnt >= BIT_HALF);
        s_nxt.sda = (s_r.cnt >= BIT_3Q);
        if (s_r.cnt == BIT_LAST) begin
          s_nxt.frames = 8'(s_r.frames + 8'h01);
          if (go_level && ((repeat_count == 8'h00) ||
              (8'(s_r.frames + 8'h01) < repeat_count))) begin
            s_nxt.state     = SEQ_START;
            s_nxt.tidx      = '0;
            s_nxt.addr      = '0;
            s_nxt.seq_start = 1'b1;
          end else begin
            s_nxt.state = SEQ_IDLE;
            s_nxt.done  = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r       <= '0;
      s_r.state <= SEQ_IDLE;
      s_r.scl   <= 1'b1;
      s_r.sda   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign txn_idx   = s_r.tidx;
  assign buf_addr  = s_r.addr;
  assign busy      = (s_r.state != SEQ_IDLE);
  assign seq_start = s_r.seq_start;
  assign ack_byte  = s_r.ack_byte;
  assign done      = s_r.done;
  assign scl_out   = s_r.scl;
  assign sda_out   = s_r.sda;

endmodule

`default_nettype wire

// ### hdl/sbc_seq_buffer.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Transaction count register is clamped to at most 40h transactions.
// - Sixty-four 8-bit length entries, one per transaction, up to FFh bytes.
// - Only the first N transactions of the sequence are sent.
// - Go with a zero count makes no activity and just clears go.
// - A zero length write sends only the target address with write bit.
// - Data port auto-increments; reads any time, writes only while idle.
// - Buffer position comes from transaction and offset pointers, both reset 00h.
// - The rewind bit returns the data port to the pointed location.
// - A 1 data bit is driven high on the serial line, a 0 low.
// - Transaction pointer is six bits, 5:0, maximum 3Fh; bits 7:6 read zero.
// - Writing the transaction pointer clears the byte offset pointer.
// - Auto-increment runs on across transaction boundaries from any new position.
// - Accesses outside the buffer from a bad transaction set the error flag.
// - Offsets outside the buffer set the error flag, drop writes, read invalid.
// - Byte offset pointer is an 8-bit index covering 256 positions.
// - Byte tally counts only acknowledged data bytes of write transactions.
// - Byte tally is cleared at the start of every sequence.
// - Repeat count is read/write, resets to 01h, reads back programmed value.
// - Repeat count 00h repeats the sequence with STOP after each until go is cleared.
// - Repeat count 01h sends once; larger values repeat that many times.
module sbc_seq_buffer
  import sbc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [7:0]       avs_writedata,
  output logic      [7:0]       avs_readdata,
  output logic                  avs_waitrequest,
  output logic      [TXN_W-1:0] target_index,
  input  wire logic [7:0]       target_addr,
  input  wire logic             ack_in,
  output logic                  scl_out,
  output logic                  sda_out
);

  typedef struct packed {
    logic [7:0]                count;
    logic [TXN_W-1:0]          tsel;
    logic [7:0]                ofs;
    logic [7:0]                tally;
    logic [7:0]                repeat_cnt;
    logic [NUM_TXN-1:0][7:0]   lens;
    logic [TXN_W-1:0]          len_sel;
    logic                      go;
    logic                      berr;
    logic [PTR_W-1:0]          dptr;
    logic                      rvalid;
    logic [7:0]                rdata;
  } sbc_host_reg_type;

  sbc_host_reg_type s_r;
  sbc_host_reg_type s_nxt;

  logic [7:0]        mem_rd_host;
  logic [7:0]        mem_rd_seq;
  logic [BUF_AW-1:0] seq_buf_addr;
  logic [TXN_W-1:0]  seq_txn_idx;
  logic              seq_busy;
  logic              seq_start;
  logic              seq_ack_byte;
  logic              seq_done;
  logic              rd_take;
  logic              wr_take;
  logic              ptr_bad;
  logic              mem_we;
  logic              go_req;
  logic [PTR_W-1:0]  base_cur;
  logic [PTR_W-1:0]  rewind_ptr;

  // ==========================================================================
  // Start address of a transaction inside the buffer
  // ==========================================================================
  // The sum spans only the entries below idx, so a change to one of them moves the rewind target at once.
  function automatic logic [PTR_W-1:0] base_of(input logic [NUM_TXN-1:0][7:0] lens,
                                               input logic [TXN_W-1:0]        idx);
    logic [PTR_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < NUM_TXN; i++) begin
      if (i < int'(idx)) begin
        acc = PTR_W'(acc + PTR_W'(lens[i]));
      end
    end
    return acc;
  endfunction

  // ==========================================================================
  // Bus handshake and buffer port decode
  // ==========================================================================
  assign rd_take         = avs_read & ~s_r.rvalid;
  assign wr_take         = avs_write;
  assign avs_waitrequest = avs_read & ~s_r.rvalid;
  assign avs_readdata    = s_r.rdata;
  // A pointer past the buffer end stays put; each further data read, or data write while idle, sets the error flag.
  assign ptr_bad         = (s_r.dptr >= BUF_LIMIT);
  // A second go while a sequence runs is dropped so the repeat count is never restarted.
  assign mem_we          = wr_take && (avs_address == IDX_DATA) && !seq_busy && !ptr_bad;
  assign go_req          = wr_take && (avs_address == IDX_CTRL) && avs_writedata[CTRL_GO] &&
                           !seq_busy && !s_r.go;
  assign base_cur        = base_of(s_r.lens, s_r.tsel);
  assign rewind_ptr      = PTR_W'(base_cur + PTR_W'(s_r.ofs));
  assign target_index    = seq_txn_idx;

  // ==========================================================================
  // Register file
  // ==========================================================================
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = rd_take;
    if (seq_done) begin
      s_nxt.go = 1'b0;
    end
    if (seq_start) begin
      s_nxt.tally = 8'h00;
    end else if (seq_ack_byte && (s_r.tally != TALLY_MAX)) begin
      s_nxt.tally = 8'(s_r.tally + 8'h01);
    end
    if (wr_take) begin
      case (avs_address)
        IDX_COUNT: begin
          s_nxt.count = (avs_writedata > TXN_MAX) ? TXN_MAX : avs_writedata;
        end
        IDX_DATA: begin
          if (!seq_busy) begin
            if (ptr_bad) begin
              s_nxt.berr = 1'b1;
            end else begin
              s_nxt.dptr = PTR_W'(s_r.dptr + 1'b1);
            end
          end
        end
        IDX_TSEL: begin
          s_nxt.tsel = avs_writedata[TXN_W-1:0];
          s_nxt.ofs  = PTR_RST;
          s_nxt.dptr = base_of(s_r.lens, avs_writedata[TXN_W-1:0]);
        end
        IDX_OFS: begin
          s_nxt.ofs  = avs_writedata;
          s_nxt.dptr = PTR_W'(base_cur + PTR_W'(avs_writedata));
        end
        IDX_REPEAT: begin
          s_nxt.repeat_cnt = avs_writedata;
        end
        IDX_LEN_SEL: begin
          s_nxt.len_sel = avs_writedata[TXN_W-1:0];
        end
        IDX_LEN_DATA: begin
          if (!seq_busy) begin
            s_nxt.lens[s_r.len_sel] = avs_writedata;
          end
        end
        IDX_CTRL: begin
          if (go_req) begin
            s_nxt.go = 1'b1;
          end else if (!avs_writedata[CTRL_GO]) begin
            s_nxt.go = 1'b0;
          end
          if (avs_writedata[CTRL_REWIND]) begin
            s_nxt.dptr = rewind_ptr;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_take) begin
      case (avs_address)
        IDX_COUNT:    s_nxt.rdata = s_r.count;
        IDX_DATA:     s_nxt.rdata = ptr_bad ? BAD_READ : mem_rd_host;
        IDX_TSEL:     s_nxt.rdata = {{(8 - TXN_W){1'b0}}, s_r.tsel};
        IDX_OFS:      s_nxt.rdata = s_r.ofs;
        IDX_TALLY:    s_nxt.rdata = s_r.tally;
        IDX_REPEAT:   s_nxt.rdata = s_r.repeat_cnt;
        IDX_LEN_SEL:  s_nxt.rdata = {{(8 - TXN_W){1'b0}}, s_r.len_sel};
        IDX_LEN_DATA: s_nxt.rdata = s_r.lens[s_r.len_sel];
        IDX_CTRL:     s_nxt.rdata = {6'h00, 1'b0, s_r.go};
        IDX_STATUS:   s_nxt.rdata = {6'h00, seq_busy, s_r.berr};
        default:      s_nxt.rdata = 8'h00;
      endcase
      if (avs_address == IDX_STATUS) begin
        s_nxt.berr = 1'b0;
      end
      if (avs_address == IDX_DATA) begin
        if (ptr_bad) begin
          s_nxt.berr = 1'b1;
        end else begin
          s_nxt.dptr = PTR_W'(s_r.dptr + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r            <= '0;
      s_r.tsel       <= TXN_W'(PTR_RST);
      s_r.ofs        <= PTR_RST;
      s_r.repeat_cnt <= REPEAT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Buffer and serial sequencer
  // ==========================================================================
  sbc_buf_mem u_mem (
    .ref_clk   (ref_clk),
    .wr_en     (mem_we),
    .wr_addr   (s_r.dptr[BUF_AW-1:0]),
    .wr_data   (avs_writedata),
    .rd_addr_a (s_r.dptr[BUF_AW-1:0]),
    .rd_data_a (mem_rd_host),
    .rd_addr_b (seq_buf_addr),
    .rd_data_b (mem_rd_seq)
  );

  sbc_tx_seq u_seq (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .start        (go_req),
    .go_level     (s_r.go),
    .txn_count    (s_r.count),
    .repeat_count (s_r.repeat_cnt),
    .cur_len      (s_r.lens[seq_txn_idx]),
    .target_addr  (target_addr),
    .buf_data     (mem_rd_seq),
    .ack_in       (ack_in),
    .txn_idx      (seq_txn_idx),
    .buf_addr     (seq_buf_addr),
    .busy         (seq_busy),
    .seq_start    (seq_start),
    .ack_byte     (seq_ack_byte),
    .done         (seq_done),
    .scl_out      (scl_out),
    .sda_out      (sda_out)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_count_max;
    s_r.count <= TXN_MAX;
  endproperty
  a_count_max: assert property (p_count_max) else $error("transaction count above maximum");

  property p_zero_count;
    $rose(s_r.go) && (s_r.count == 8'h00) |-> seq_done ##1 (!s_r.go && !seq_busy);
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count go not cleared quietly");

  property p_busy_write;
    wr_take && (avs_address == IDX_DATA) && seq_busy |-> !mem_we ##1 (s_r.dptr == $past(s_r.dptr));
  endproperty
  a_busy_write: assert property (p_busy_write) else $error("data write taken while busy");

  property p_rewind;
    wr_take && (avs_address == IDX_CTRL) && avs_writedata[CTRL_REWIND] |=> s_r.dptr == $past(rewind_ptr);
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind did not restore pointer");

  property p_tsel_clears_ofs;
    wr_take && (avs_address == IDX_TSEL) |=> (s_r.ofs == PTR_RST) && (s_r.dptr == base_cur);
  endproperty
  a_tsel_clears_ofs: assert property (p_tsel_clears_ofs) else $error("offset not cleared on select");

  property p_bad_read;
    rd_take && (avs_address == IDX_DATA) && ptr_bad |=> s_r.berr && (s_r.rdata == BAD_READ);
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("bad buffer read not flagged");

  property p_tally_count;
    seq_ack_byte && !seq_start && (s_r.tally != TALLY_MAX) |=> s_r.tally == 8'($past(s_r.tally) + 8'h01);
  endproperty
  a_tally_count: assert property (p_tally_count) else $error("tally missed acknowledged byte");

  property p_tally_clear;
    seq_start |=> (s_r.tally == 8'h00);
  endproperty
  a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared at start");

  property p_repeat_read;
    rd_take && (avs_address == IDX_REPEAT) |=> s_r.rdata == $past(s_r.repeat_cnt);
  endproperty
  a_repeat_read: assert property (p_repeat_read) else $error("repeat count read wrong");

  property p_read_latency;
    avs_read && !s_r.rvalid |=> !avs_waitrequest;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  property p_ofs_write;
    wr_take && (avs_address == IDX_OFS) |=> (s_r.ofs == $past(avs_writedata)) && (s_r.dptr == rewind_ptr);
  endproperty
  a_ofs_write: assert property (p_ofs_write) else $error("offset write did not set pointer");

  property p_data_step;
    mem_we || (rd_take && (avs_address == IDX_DATA) && !ptr_bad) |=> s_r.dptr == PTR_W'($past(s_r.dptr) + 1'b1);
  endproperty
  a_data_step: assert property (p_data_step) else $error("data pointer did not advance");

  property p_bad_write;
    wr_take && (avs_address == IDX_DATA) && !seq_busy && ptr_bad |-> !mem_we ##1 s_r.berr;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("out of buffer write not flagged");

  property p_ptr_freeze;
    (wr_take || rd_take) && (avs_address == IDX_DATA) && ptr_bad |=> s_r.dptr == $past(s_r.dptr);
  endproperty
  a_ptr_freeze: assert property (p_ptr_freeze) else $error("bad pointer moved");

  property p_tsel_read;
    rd_take && (avs_address == IDX_TSEL) |=> s_r.rdata == {{(8 - TXN_W){1'b0}}, $past(s_r.tsel)};
  endproperty
  a_tsel_read: assert property (p_tsel_read) else $error("transaction pointer read wrong");

  property p_done_go;
    seq_done |=> !s_r.go;
  endproperty
  a_done_go: assert property (p_done_go) else $error("go not cleared after last sequence");

  // ==========================================================================
  // Cover points
  // ==========================================================================
  c_sequence_run: cover property (seq_start ##[1:1000] seq_done);
  c_zero_count:   cover property ($rose(s_r.go) && (s_r.count == 8'h00));
  c_bad_access:   cover property ($rose(s_r.berr));
  c_tally_up:     cover property (seq_ack_byte);
  c_repeat_run:   cover property (seq_start && $past(seq_busy));

endmodule

`default_nettype wire

// ### tb/sbc_target_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbc_target_model
  import sbc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic [TXN_W-1:0] target_index,
  output logic      [7:0]       target_addr,
  output logic                  ack_in,
  input  wire logic             scl_out,
  input  wire logic             sda_out,
  output logic      [7:0]       rx_byte,
  output logic                  addr_err,
  output logic      [7:0]       n_bytes
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [1:0] prev = 2'h3;
  logic       first = 1'b0;
  logic       err = 1'b0;
  logic [7:0] nb = 8'h00;
  assign ack_in = (cnt == 4'h8) ? 1'b0 : ~prev[0];
  assign target_addr = {target_index, 2'h1};
  assign addr_err = err;
  assign n_bytes = nb;
  always @(posedge ref_clk) begin
    prev <= {scl_out, sda_out};
    if (prev == 2'h3 && scl_out && !sda_out) begin
      cnt <= 4'h0;
      first <= 1'b1;
    end else if (!prev[1] && scl_out) begin
      sh <= {sh[6:0], sda_out};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8) begin
        rx_byte <= sh;
        nb <= nb + 8'h01;
        first <= 1'b0;
        if (first && (sh != {target_addr[7:1], WR_DIR})) err <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import sbc_pkg::*;
;
  logic             ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]       avs_address = 8'h00, avs_writedata = 8'h00, last_rd = 8'hFF;
  logic [7:0]       avs_readdata, rx_byte, target_addr, n_bytes, nb0, d [5];
  logic [15:0]      expq [$];
  logic [TXN_W-1:0] target_index;
  logic             avs_waitrequest, ack_in, scl_out, sda_out, addr_err;
  int               failures = 0, n_tests = 0;
  sbc_seq_buffer dut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .target_index, .target_addr, .ack_in, .scl_out, .sda_out);
  sbc_target_model far_end (.ref_clk, .target_index, .target_addr, .ack_in, .scl_out, .sda_out, .rx_byte,
    .addr_err, .n_bytes);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic wrap_up(input bit to = 1'b0);
    if (to) failures++;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, x);
    n_tests++;
    if (g !== x) failures++;
    if (g !== x) $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, dat, m);
    int n = 0;
    {avs_address, avs_writedata} <= {a, dat};
    {avs_write, avs_read} <= {wr, ~wr};
    if (!wr) expq.push_back({m, dat});
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
    last_rd = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
    @(posedge ref_clk);
    if (n == 20) wrap_up(1'b1);
  endtask
  task automatic w(input logic [7:0] a, dat); acc(1'b1, a, dat, 8'h00); endtask
  task automatic r(input logic [7:0] a, dat); acc(1'b0, a, dat, 8'hFF); endtask
  task automatic rs(input logic [7:0] dat); acc(1'b0, IDX_STATUS, dat, 8'h01); endtask
  task automatic wait_idle();
    int k = 0;
    do begin
      rs(8'h00);
      k++;
    end while (last_rd[STAT_BUSY] !== 1'b0 && k < 1000);
    if (last_rd[STAT_BUSY] !== 1'b0) wrap_up(1'b1);
  endtask
  always @(posedge ref_clk)
    if (avs_read && avs_waitrequest === 1'b0) begin
      cmp(avs_readdata & expq[0][15:8], expq[0][7:0]);
      void'(expq.pop_front());
    end
  initial begin
    void'($urandom(32'ha396afed));
    foreach (d[i]) d[i] = 8'($urandom());
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    r(IDX_TSEL, PTR_RST);
    r(IDX_REPEAT, REPEAT_RST);
    w(IDX_COUNT, 8'h41);
    r(IDX_COUNT, TXN_MAX);
    w(IDX_LEN_SEL, 8'h00);
    w(IDX_LEN_DATA, 8'h02);
    foreach (d[i]) w(IDX_DATA, d[i]);
    w(IDX_OFS, 8'h01);
    w(IDX_TSEL, 8'h41);
    r(IDX_OFS, 8'h00);
    r(IDX_DATA, d[2]);
    w(IDX_CTRL, 8'h02);
    r(IDX_DATA, d[2]);
    $display("test registers done");
    w(IDX_COUNT, 8'h01);
    w(IDX_CTRL, 8'h01);
    w(IDX_DATA, ~d[3]);
    wait_idle();
    r(IDX_TALLY, 8'h02);
    cmp(rx_byte, d[1]);
    r(IDX_DATA, d[3]);
    w(IDX_COUNT, 8'h00);
    w(IDX_CTRL, 8'h01);
    r(IDX_TALLY, 8'h02);
    r(IDX_CTRL, 8'h00);
    $display("test sequence done");
    for (int i = 0; i < 20; i++) begin
      w(IDX_LEN_SEL, 8'(i));
      w(IDX_LEN_DATA, 8'hFF);
    end
    w(IDX_TSEL, 8'h11);
    w(IDX_OFS, 8'hFF);
    w(IDX_DATA, 8'h5A);
    rs(8'h01);
    w(IDX_TSEL, 8'h14);
    r(IDX_DATA, BAD_READ);
    rs(8'h01);
    r(8'h00, 8'h00);
    $display("test buffer errors done");
    w(IDX_COUNT, 8'h02);
    w(IDX_LEN_SEL, 8'h00);
    w(IDX_LEN_DATA, 8'h00);
    w(IDX_LEN_SEL, 8'h01);
    w(IDX_LEN_DATA, 8'h01);
    w(IDX_REPEAT, 8'h02);
    nb0 = n_bytes;
    w(IDX_CTRL, 8'h01);
    wait_idle();
    cmp(8'(n_bytes - nb0), 8'h06);
    r(IDX_TALLY, 8'h01);
    cmp(rx_byte, d[0]);
    cmp({7'h00, addr_err}, 8'h00);
    w(IDX_REPEAT, 8'h00);
    nb0 = n_bytes;
    w(IDX_CTRL, 8'h01);
    repeat (800) @(posedge ref_clk);
    w(IDX_CTRL, 8'h00);
    wait_idle();
    cmp(8'(n_bytes - nb0), 8'h06);
    r(IDX_CTRL, 8'h00);
    $display("test repeat done");
    wrap_up();
  end
endmodule
`default_nettype wire
